// ### hdl/dram_refresh_defines.svh
// constants for the dram refresh controller
//
// Notes on behaviour
// [RULE1] keep 8-bit refresh address counter, present it
// [RULE2] own interval timer starts refresh cycles
// [RULE3] control bit 7 enables refresh insertion
// [RULE4] insert refresh at next machine cycle boundary
// [RULE5] address on low lines, strobe driven low
// [RULE6] control bit 6: two or three clocks
// [RULE7] ignore external and programmed wait states
// [RULE8] interval select: 10, 20, 40, 80 states
// [RULE9] reset: interval 00, enable and wait set
// [RULE10] software picks interval meeting memory refresh need
// [RULE11] no refresh in reset, grant, sleep, wait
// [RULE12] bus granted: suppress refresh, timer keeps running
// [RULE13] sleep request held, inserted after sleep exit
// [RULE14] address advances only per performed refresh
// [RULE15] address counter wraps to zero
`ifndef DRAM_REFRESH_DEFINES_SVH
`define DRAM_REFRESH_DEFINES_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define REFRESH_CTRL_ADDR  8'h36
`define REFRESH_CTRL_RESET 8'hC0
`define CTRL_ENABLE_BIT    7
`define CTRL_WAIT_BIT      6
`define CTRL_SEL_MSB       1
`define CTRL_SEL_LSB       0

// ----------------------------------------
// timing in clock states
// ----------------------------------------
`define INTERVAL_SEL0      7'h0A
`define INTERVAL_SEL1      7'h14
`define INTERVAL_SEL2      7'h28
`define INTERVAL_SEL3      7'h50
`define INTERVAL_CNT_ONE   7'h01
`define ADDR_STEP          8'h01

`endif

// ### hdl/dram_refresh_pkg.sv
// types shared by the dram refresh controller
`default_nettype none

package dram_refresh_pkg;

  // refresh bus cycle states
  typedef enum logic [1:0] {
    IDLE,
    T1,
    T2,
    REFRESH_WAIT_STATE
  } refresh_state_t;

  // software view of the control register
  typedef struct packed {
    logic       refreshEnableBit;
    logic       refreshWaitBit;
    logic [1:0] refreshIntervalSelect;
  } refresh_ctrl_t;

  // cpu sequencer status, same clock domain
  typedef struct packed {
    logic cycleBoundary;
    logic busGranted;
    logic sleepMode;
    logic waitState;
  } cpu_status_t;

endpackage

`default_nettype wire

// ### hdl/refresh_interval_timer.sv
// free running refresh interval timer
`include "dram_refresh_defines.svh"
`default_nettype none

module refresh_interval_timer
#(
  parameter int CNT_W = 7
)
(
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  // interval in clock states
  input  wire logic [CNT_W-1:0] period,
  // one-cycle request pulse
  output logic                  refreshDue
);

  logic [CNT_W-1:0] stateCount;
  logic [CNT_W-1:0] next_stateCount;
  logic             next_refreshDue;

  // wrap at the period; >= covers a shortened period mid-count
  always_comb
  begin
    next_refreshDue = 1'b0;
    next_stateCount = stateCount + `INTERVAL_CNT_ONE;
    if (stateCount >= period - `INTERVAL_CNT_ONE)
    begin
      next_stateCount = '0;
      next_refreshDue = 1'b1; // [RULE2]
    end
  end

  // never stops for bus grant or sleep, only for reset or clock enable low
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stateCount <= '0;
      refreshDue <= 1'b0;
    end
    else if (ce)
    begin
      stateCount <= next_stateCount; // [RULE12]
      refreshDue <= next_refreshDue;
    end
  end

  // due pulse at the 10-state interval is followed by nine clocks of silence
  a_due_spacing : assert property (@(posedge ref_clk) disable iff (!rst_n || !ce) // [RULE8]
    refreshDue && period == `INTERVAL_SEL0 |=> !refreshDue [*8] ##1 !refreshDue)
    else $error("refresh due pulses closer than interval");

endmodule

`default_nettype wire

// ### hdl/dram_refresh_controller.sv
// dram refresh controller: control register, timer, refresh cycle
`include "dram_refresh_defines.svh"
`default_nettype none

module dram_refresh_controller
#(
  parameter int ADDR_W = 8,
  parameter int CNT_W  = 7
)
(
  // clock, reset, enable
  input  wire logic                       ref_clk,
  input  wire logic                       rst_n,
  input  wire logic                       ce,
  // internal i/o register port
  input  wire logic [7:0]                 ioAddr,
  input  wire logic                       ioWrStb,
  input  wire logic                       ioRdStb,
  input  wire logic [7:0]                 ioWrData,
  output logic [7:0]                      ioRdData,
  // cpu sequencer status
  input  wire dram_refresh_pkg::cpu_status_t cpuStatus,
  // refresh bus cycle
  output logic                            refreshActive,
  output logic [ADDR_W-1:0]               refreshAddr,
  output logic                            refresh_strobe_n
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------

  // interval select to clock states
  function automatic logic [CNT_W-1:0] interval_states(input logic [1:0] sel);
    logic [CNT_W-1:0] r;
    case (sel)
      2'h0:    r = `INTERVAL_SEL0;
      2'h1:    r = `INTERVAL_SEL1;
      2'h2:    r = `INTERVAL_SEL2;
      default: r = `INTERVAL_SEL3;
    endcase
    return r; // [RULE8]
  endfunction

  // ----------------------------------------
  // control register
  // ----------------------------------------
  dram_refresh_pkg::refresh_ctrl_t refreshControl;
  dram_refresh_pkg::refresh_ctrl_t next_refreshControl;
  logic [7:0]                      next_ioRdData;
  logic                            ctrlHit;

  // reset image of the control register, sliced per field below
  localparam logic [7:0] CTRL_RESET = `REFRESH_CTRL_RESET;

  assign ctrlHit = (ioAddr == `REFRESH_CTRL_ADDR);

  // write decode and read mux; unused bits read zero
  always_comb
  begin
    next_refreshControl = refreshControl;
    next_ioRdData       = ioRdData;
    if (ioWrStb && ctrlHit)
    begin
      next_refreshControl.refreshEnableBit      = ioWrData[`CTRL_ENABLE_BIT];
      next_refreshControl.refreshWaitBit        = ioWrData[`CTRL_WAIT_BIT];
      next_refreshControl.refreshIntervalSelect = ioWrData[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
    end
    if (ioRdStb)
    begin
      next_ioRdData = '0;
      if (ctrlHit)
      begin
        next_ioRdData[`CTRL_ENABLE_BIT]              = refreshControl.refreshEnableBit;
        next_ioRdData[`CTRL_WAIT_BIT]                = refreshControl.refreshWaitBit;
        next_ioRdData[`CTRL_SEL_MSB:`CTRL_SEL_LSB]   = refreshControl.refreshIntervalSelect;
      end
    end
  end

  // reset value: enabled, long cycle, shortest interval
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      refreshControl.refreshEnableBit      <= CTRL_RESET[`CTRL_ENABLE_BIT]; // [RULE9]
      refreshControl.refreshWaitBit        <= CTRL_RESET[`CTRL_WAIT_BIT]; // [RULE9]
      refreshControl.refreshIntervalSelect <= CTRL_RESET[`CTRL_SEL_MSB:`CTRL_SEL_LSB]; // [RULE9]
      ioRdData                             <= '0;
    end
    else if (ce)
    begin
      refreshControl <= next_refreshControl;
      ioRdData       <= next_ioRdData;
    end
  end

  // ----------------------------------------
  // interval timer
  // ----------------------------------------
  logic refreshDue;

  refresh_interval_timer #(
    .CNT_W      (CNT_W)
  ) u_timer (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .ce         (ce),
    .period     (interval_states(refreshControl.refreshIntervalSelect)),
    .refreshDue (refreshDue)
  );

  // ----------------------------------------
  // request latch and refresh cycle sequencer
  // ----------------------------------------
  dram_refresh_pkg::refresh_state_t state;
  dram_refresh_pkg::refresh_state_t next_state;
  logic                             pending;
  logic                             next_pending;
  logic                             longCycle;
  logic                             next_longCycle;
  logic [ADDR_W-1:0]                next_refreshAddr;
  logic                             next_strobeN;
  logic                             startRefresh;

  // a cycle may only start at a boundary with the bus ours and idle
  assign startRefresh = pending && refreshControl.refreshEnableBit // [RULE3]
                        && cpuStatus.cycleBoundary // [RULE4]
                        && !cpuStatus.busGranted && !cpuStatus.sleepMode
                        && !cpuStatus.waitState // [RULE11]
                        && (state == dram_refresh_pkg::IDLE);

  // latch: a new request replaces the old; it wins over the start clear
  always_comb
  begin
    next_pending = pending;
    if (startRefresh)
      next_pending = 1'b0;
    if (cpuStatus.busGranted || !refreshControl.refreshEnableBit)
      next_pending = 1'b0; // [RULE12]
    if (refreshDue && !cpuStatus.busGranted)
      next_pending = 1'b1; // [RULE13]
  end

  // states T1, T2 and the optional refresh wait state
  always_comb
  begin
    next_state       = state;
    next_longCycle   = longCycle;
    next_refreshAddr = refreshAddr;
    case (state)
      dram_refresh_pkg::IDLE:
      begin
        if (startRefresh)
        begin
          next_state     = dram_refresh_pkg::T1;
          next_longCycle = refreshControl.refreshWaitBit; // [RULE6]
        end
      end
      dram_refresh_pkg::T1:
        next_state = dram_refresh_pkg::T2;
      dram_refresh_pkg::T2:
      begin
        // no wait input is looked at here
        if (longCycle)
          next_state = dram_refresh_pkg::REFRESH_WAIT_STATE; // [RULE7]
        else
        begin
          next_state       = dram_refresh_pkg::IDLE;
          next_refreshAddr = refreshAddr + `ADDR_STEP; // [RULE14]
        end
      end
      dram_refresh_pkg::REFRESH_WAIT_STATE:
      begin
        next_state       = dram_refresh_pkg::IDLE;
        next_refreshAddr = refreshAddr + `ADDR_STEP; // [RULE15]
      end
      default:
        next_state = dram_refresh_pkg::IDLE;
    endcase
    next_strobeN = (next_state == dram_refresh_pkg::IDLE); // [RULE5]
  end

  // registers; address holds for the whole cycle, steps after it
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state            <= dram_refresh_pkg::IDLE;
      pending          <= 1'b0;
      longCycle        <= 1'b0;
      refreshAddr      <= '0;
      refresh_strobe_n <= 1'b1;
    end
    else if (ce)
    begin
      state            <= next_state;
      pending          <= next_pending;
      longCycle        <= next_longCycle;
      refreshAddr      <= next_refreshAddr; // [RULE1]
      refresh_strobe_n <= next_strobeN;
    end
  end

  // stalls the cpu sequencer while the refresh owns the bus
  assign refreshActive = (state != dram_refresh_pkg::IDLE); // [RULE5]

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_short_cycle : assert property (@(posedge ref_clk) disable iff (!rst_n || !ce) // [RULE6]
    $fell(refresh_strobe_n) && !longCycle |-> !refresh_strobe_n [*2] ##1 refresh_strobe_n)
    else $error("short refresh cycle not two clocks");

  a_long_cycle : assert property (@(posedge ref_clk) disable iff (!rst_n || !ce) // [RULE6]
    $fell(refresh_strobe_n) && longCycle |-> !refresh_strobe_n [*3] ##1 refresh_strobe_n)
    else $error("long refresh cycle not three clocks");

  a_addr_step : assert property (@(posedge ref_clk) disable iff (!rst_n || !ce) // [RULE14]
    $rose(refresh_strobe_n) |-> refreshAddr == $past(refreshAddr) + `ADDR_STEP)
    else $error("refresh address did not step by one");

  a_addr_hold : assert property (@(posedge ref_clk) disable iff (!rst_n || !ce) // [RULE1]
    !refresh_strobe_n && !$rose(refresh_strobe_n) |=> $stable(refreshAddr) || refresh_strobe_n)
    else $error("refresh address moved inside a cycle");

  a_no_start_blocked : assert property (@(posedge ref_clk) disable iff (!rst_n || !ce) // [RULE11]
    state == dram_refresh_pkg::IDLE && (cpuStatus.busGranted || cpuStatus.sleepMode
      || cpuStatus.waitState || !cpuStatus.cycleBoundary) |=> refresh_strobe_n)
    else $error("refresh started while blocked");

  a_no_start_off : assert property (@(posedge ref_clk) disable iff (!rst_n || !ce) // [RULE3]
    state == dram_refresh_pkg::IDLE && !refreshControl.refreshEnableBit |=> refresh_strobe_n)
    else $error("refresh started while disabled");

  a_start_due : assert property (@(posedge ref_clk) disable iff (!rst_n || !ce) // [RULE4]
    state == dram_refresh_pkg::IDLE && pending && refreshControl.refreshEnableBit
      && cpuStatus.cycleBoundary && !cpuStatus.busGranted && !cpuStatus.sleepMode
      && !cpuStatus.waitState |=> !refresh_strobe_n && refreshActive)
    else $error("due refresh not inserted at boundary");

  a_grant_drops : assert property (@(posedge ref_clk) disable iff (!rst_n || !ce) // [RULE12]
    cpuStatus.busGranted |=> !pending)
    else $error("request kept across bus grant");

endmodule

`default_nettype wire

// ### test/dram_array_model.sv
// partner model: dram array that records each refreshed row
`default_nettype none

module dram_array_model
(
  // refresh side of the system bus
  input  wire logic       ref_clk,
  input  wire logic       refresh_strobe_n,
  input  wire logic [7:0] rowAddr,
  // observation for the bench
  output logic [15:0]     rowsRefreshed,
  output logic [7:0]      lastRow
);
  timeunit 1ns;
  timeprecision 1ps;

  logic strobeDly;

  // -------------------------------------
  // row capture
  // -------------------------------------
  // a row counts once per falling strobe, so a stretched cycle is not counted twice
  initial
  begin
    strobeDly = 1'b1;
    rowsRefreshed = 16'h0000;
    lastRow = 8'h00;
  end

  always @(posedge ref_clk)
  begin
    strobeDly <= refresh_strobe_n;
    if (strobeDly && !refresh_strobe_n)
    begin
      rowsRefreshed <= rowsRefreshed + 16'h0001;
      lastRow       <= rowAddr;
    end
  end
endmodule

`default_nettype wire

// ### test/dram_refresh_controller_tb.sv
// self-checking bench for the dram refresh controller
`default_nettype none

module dram_refresh_controller_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // -------------------------------------
  // signals
  // -------------------------------------
  logic                          ref_clk;
  logic                          rst_n;
  logic                          ce;
  logic [7:0]                    ioAddr;
  logic                          ioWrStb;
  logic                          ioRdStb;
  logic [7:0]                    ioWrData;
  logic [7:0]                    ioRdData;
  dram_refresh_pkg::cpu_status_t cpuStatus;
  logic                          refreshActive;
  logic [7:0]                    refreshAddr;
  logic                          refresh_strobe_n;
  logic [15:0]                   rowsRefreshed;
  logic [7:0]                    lastRow;
  int                            num_errors = 0;
  int                            checks = 0;
  int                            cyc = 0;

  // -------------------------------------
  // instances
  // -------------------------------------
  dram_refresh_controller #(.ADDR_W(8), .CNT_W(7)) i_dram_refresh_controller
  (
    .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .ioAddr(ioAddr), .ioWrStb(ioWrStb),
    .ioRdStb(ioRdStb), .ioWrData(ioWrData), .ioRdData(ioRdData), .cpuStatus(cpuStatus),
    .refreshActive(refreshActive), .refreshAddr(refreshAddr), .refresh_strobe_n(refresh_strobe_n)
  );

  dram_array_model i_dram_array_model
  (
    .ref_clk(ref_clk), .refresh_strobe_n(refresh_strobe_n), .rowAddr(refreshAddr),
    .rowsRefreshed(rowsRefreshed), .lastRow(lastRow)
  );

  // 200 MHz clock and a cycle stamp for spacing measurements
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) cyc <= cyc + 1;

  // -------------------------------------
  // shared tasks
  // -------------------------------------
  task automatic test_done();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // inputs always move 1 ns after the edge, outputs are read there too
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
    ioAddr = a;
    ioWrData = d;
    ioWrStb = 1'b1;
    step(1);
    ioWrStb = 1'b0;
    step(1);
  endtask

  task automatic rdReg(input logic [7:0] a, output logic [7:0] d);
    ioAddr = a;
    ioRdStb = 1'b1;
    step(1);
    d = ioRdData;
    ioRdStb = 1'b0;
    step(1);
  endtask

  // waits for a strobe fall (at = -1 if none) and counts its low clocks
  task automatic nextRefresh(input int lim, input logic holdWait, output int at, output int w);
    at = -1;
    w = 0;
    for (int n = 0; n < lim && at < 0; n++)
    begin
      step(1);
      if (refresh_strobe_n === 1'b0) at = cyc;
    end
    if (at >= 0) check("active in cycle", 1, refreshActive);
    if (at >= 0 && holdWait) cpuStatus.waitState = 1'b1;
    while (refresh_strobe_n === 1'b0 && w < 8)
    begin
      w++;
      step(1);
    end
    if (at >= 0 && holdWait) cpuStatus.waitState = 1'b0;
  endtask

  // -------------------------------------
  // scenarios
  // -------------------------------------
  task automatic t_reset();
    logic [7:0] d;
    check("addr after reset", 0, refreshAddr);
    rdReg(8'h36, d);
    check("control reset", 32'h0000_00C0, d);
    rdReg(8'h35, d);
    check("unmapped read", 0, d);
  endtask

  // every interval code with both lengths; spacing taken once the new code has settled
  task automatic t_interval();
    int t0, t1, w;
    logic [7:0] a0;
    for (int s = 0; s < 4; s++)
      for (int wt = 0; wt < 2; wt++)
      begin
        wrReg(8'h36, {1'b1, wt[0], 4'h0, s[1:0]});
        nextRefresh(200, 1'b0, t0, w);
        nextRefresh(200, 1'b0, t0, w);
        a0 = lastRow;
        nextRefresh(200, 1'b1, t1, w);
        check("spacing", 10 << s, t1 - t0);
        check("strobe width", 2 + wt, w);
        check("row step", 8'(a0 + 8'h01), lastRow);
      end
  endtask

  task automatic t_disable();
    int t, w;
    logic [7:0] d;
    wrReg(8'h36, 8'h40);
    nextRefresh(300, 1'b0, t, w);
    check("disabled", 32'hFFFF_FFFF, t);
    rdReg(8'h36, d);
    check("control readback", 32'h0000_0040, d);
    // reset in mid-run restores the defaults
    rst_n = 1'b0;
    step(2);
    rst_n = 1'b1;
    check("addr after mid reset", 0, refreshAddr);
    rdReg(8'h36, d);
    check("control mid reset", 32'h0000_00C0, d);
  endtask

  // clock enable low freezes timer, latch and address
  task automatic t_freeze();
    logic [7:0] a;
    int t, w;
    nextRefresh(20, 1'b0, t, w);
    a = refreshAddr;
    ce = 1'b0;
    nextRefresh(40, 1'b0, t, w);
    check("frozen", 32'hFFFF_FFFF, t);
    check("frozen addr", a, refreshAddr);
    ce = 1'b1;
    nextRefresh(12, 1'b0, t, w);
    check("after thaw", 1, t >= 0);
  endtask

  // no boundary, bus granted, sleep, wait state: each blocks, then release
  task automatic t_gates();
    logic [3:0] hold [4] = '{4'h0, 4'hC, 4'hA, 4'h9};
    logic [7:0] a;
    int t, w;
    wrReg(8'h36, 8'h80); // 10-state interval, short enough for fast memory
    for (int k = 0; k < 4; k++)
    begin
      nextRefresh(20, 1'b0, t, w);
      a = refreshAddr;
      cpuStatus = hold[k];
      nextRefresh(60, 1'b0, t, w);
      check("blocked", 32'hFFFF_FFFF, t);
      check("addr held", a, refreshAddr);
      cpuStatus = 4'h8;
      nextRefresh((k == 1) ? 12 : 2, 1'b0, t, w);
      check("after release", 1, t >= 0);
    end
  endtask

  task automatic t_wrap();
    logic [7:0] a;
    logic [15:0] r0;
    int t, w;
    nextRefresh(20, 1'b0, t, w);
    a = refreshAddr;
    r0 = rowsRefreshed;
    repeat (256) nextRefresh(20, 1'b0, t, w);
    check("addr wrap", a, refreshAddr);
    check("rows done", 256, rowsRefreshed - r0);
  endtask

  // -------------------------------------
  // main sequence and watchdog
  // -------------------------------------
  initial
  begin
    rst_n = 1'b0;
    ce = 1'b1;
    ioAddr = 8'h00;
    ioWrStb = 1'b0;
    ioRdStb = 1'b0;
    ioWrData = 8'h00;
    cpuStatus = 4'h8;
    step(10);
    rst_n = 1'b1;
    t_reset();
    t_interval();
    t_disable();
    t_gates();
    t_freeze();
    t_wrap();
    test_done();
  end

  // about five times the expected run
  initial
  begin
    #100us;
    num_errors++;
    test_done();
  end
endmodule

`default_nettype wire
